// *** logic/jib_cfg.svh ***
// Purpose: constants of the test access port instruction block
// Assumes: included by the package and the design files
// Notes:   opcodes are shifted in least significant bit first
//
// What this block does
// - EXTEST puts 184-bit scan chain on TDI/TDO
// - EXTEST asserts internal reset, runs keep-alive
// - Keep-alive frees clock pins for scan
// - HIGHZ: keep-alive, reset, bypass, pins high-Z
// - Test reset or five TMS ones: reset
// - Capture-IR then update-IR selects HIGHZ
// - SAMPLE captures pins, shifts without disturbing system
// - SAMPLE update-DR preloads cells for EXTEST
// - Drive-test: zero large driver, one small
// - Drive-test captures exactly like EXTEST
// - Drive-test: keep-alive, reset, test owns pins
// - Pin reset release loads drive latch from priorities
// - Drive latch held under drive-test, EXTEST, SHUTDOWN
// - Test-logic-reset returns instruction to bypass
// - SHUTDOWN: reset, keep-alive, bypass, clamped pins
// - Reserved opcode leaves pins as in system
// - Drive-system update sets drivers, system owns pins
// - Later reset releases may reload drive latch
// - BYPASS gives one-bit path TDI to TDO
// - Bypass stage captures zero in capture-DR
// - Three-bit IR, LSB first, resets to ones
// - Capture-IR loads 001
// - Opcode decode of all eight instructions
// - TDO driven only in shift states, on falls
`ifndef JIB_CFG_SVH
`define JIB_CFG_SVH
`define JIB_BSR_LEN   184
`define JIB_IR_W      3
`define JIB_OP_EXTEST 3'h0
`define JIB_OP_HIGHZ  3'h1
`define JIB_OP_SAMPLE 3'h2
`define JIB_OP_DRVT   3'h3
`define JIB_OP_SHUTDN 3'h4
`define JIB_OP_PRIV   3'h5
`define JIB_OP_DRVS   3'h6
`define JIB_OP_BYPASS 3'h7
`define JIB_IR_CAPT   3'h1
`define JIB_DRV_W     3
`define JIB_DRV_CELL  0
`define JIB_KA_DIV    3'h7
`define JIB_FIFO_W    2
`define JIB_FIFO_D    16
`define JIB_SYNC_W    8
`endif

// *** logic/jib_pkg.sv ***
// Purpose: types of the test access port instruction block
// Assumes: constants come from the cfg header
// Notes:   the core state is one packed struct
package jib_pkg;
`include "jib_cfg.svh"
    typedef enum logic [3:0] {
        TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PSDR, EX2DR, UPDDR,
        SELIR, CAPIR, SHIR, EX1IR, PSIR, EX2IR, UPDIR
    } jib_tap_t;
    typedef struct packed {
        jib_tap_t                 tap;
        logic [`JIB_IR_W-1:0]     ir;
        logic [`JIB_IR_W-1:0]     instr;
        logic                     byp;
        logic [`JIB_BSR_LEN-1:0]  bsr;
        logic [`JIB_BSR_LEN-1:0]  upd;
        logic [`JIB_DRV_W-1:0]    drv;
        logic                     tdo;
        logic                     tdoOe;
        logic                     tckPrev;
        logic                     rstPrev;
        logic [2:0]               kaCnt;
        logic                     kaTick;
        logic                     lost;
    } jib_core_t;
endpackage

// *** logic/jib_if.sv ***
// Purpose: carries pin events between sampler and tap engine
// Assumes: one clock domain
// Notes:   data is {tms, tdi} of one rising test clock edge
`timescale 1ns/1ns
`include "jib_cfg.svh"
interface jib_if;
    logic                   wrValid;
    logic                   wrReady;
    logic [`JIB_FIFO_W-1:0] wrData;
    logic                   rdValid;
    logic                   rdReady;
    logic [`JIB_FIFO_W-1:0] rdData;
    modport core (output wrValid, wrData, rdReady,
                  input  wrReady, rdValid, rdData);
    modport fifo (input  wrValid, wrData, rdReady,
                  output wrReady, rdValid, rdData);
endinterface

// *** logic/jib_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to core_clk
// Notes:   only the second stage is read outside
`timescale 1ns/1ns
module jib_sync #(
    parameter int                W   = 1,
    parameter logic [W-1:0]      RST = '0
) (
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    // Data
    input  wire logic [W-1:0]   din,
    output logic      [W-1:0]   dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RST;
            dout   <= RST;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// *** logic/jib_fifo.sv ***
// Purpose: event FIFO between pin sampler and tap engine
// Assumes: single clock
// Notes:   full and empty are exact; depth a power of two
`timescale 1ns/1ns
module jib_fifo #(
    parameter int W = 2,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Both sides
    jib_if.fifo       f
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW:0]   wp_q;
    logic [AW:0]   rp_q;
    logic          push;
    logic          pop;
    assign f.wrReady = (wp_q - rp_q) != (AW+1)'(D);
    assign f.rdValid = wp_q != rp_q;
    assign f.rdData  = mem[rp_q[AW-1:0]];
    assign push      = f.wrValid && f.wrReady;
    assign pop       = f.rdValid && f.rdReady;
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= f.wrData;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule

// *** logic/jib_core.sv ***
// Purpose: instruction behaviour of the boundary-scan test logic
// Assumes: test pins are sampled by core_clk, far faster than tck
// Notes:   rising tck events queue in a FIFO; scanHold stalls them
`timescale 1ns/1ns
`include "jib_cfg.svh"
module jib_core
    import jib_pkg::*;
(
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    // Test access pins
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    input  wire logic                        trstN,
    output logic                             tdo,
    output logic                             tdoOe,
    // System side pins
    input  wire logic                        resetInputPinN,
    input  wire logic [`JIB_DRV_W-1:0]       interruptPriorityPins,
    input  wire logic [`JIB_BSR_LEN-1:0]     sysCapture,
    // Scan engine control
    input  wire logic                        scanHold,
    output logic                             eventLost,
    // Test effects
    output logic [`JIB_BSR_LEN-1:0]          scanOut,
    output logic [`JIB_DRV_W-1:0]            driveSelect,
    output logic                             testOwnsPins,
    output logic                             pinsHighZ,
    output logic                             internalReset,
    output logic                             keepAliveTick
);
    import jib_pkg::*;

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    logic [`JIB_SYNC_W-1:0]   syncIn;
    logic [`JIB_SYNC_W-1:0]   syncOut;
    logic                     tckS;
    logic                     tmsS;
    logic                     tdiS;
    logic                     trstS;
    logic                     rstInS;
    logic [`JIB_DRV_W-1:0]    iplS;

    assign syncIn = {interruptPriorityPins, resetInputPinN, trstN,
                     tdi, tms, tck};
    // Reset reads every pin as low, so a held pin release loads the latch
    jib_sync #(
        .W   (`JIB_SYNC_W),
        .RST (8'h00)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (syncIn),
        .dout     (syncOut)
    );
    assign tckS   = syncOut[0];
    assign tmsS   = syncOut[1];
    assign tdiS   = syncOut[2];
    assign trstS  = syncOut[3];
    assign rstInS = syncOut[4];
    assign iplS   = syncOut[7:5];

    // ---------------------------------------------
    // Event queue
    // ---------------------------------------------
    // Queueing keeps up to 16 tck edges from being lost while scanHold stalls
    jib_if f ();
    jib_core_t q;
    jib_core_t d;
    logic      riseE;
    logic      fallE;
    logic      step;
    logic      tmsB;
    logic      tdiB;

    assign riseE     = tckS && !q.tckPrev;
    assign fallE     = !tckS && q.tckPrev;
    assign f.wrValid = riseE;
    assign f.wrData  = {tmsS, tdiS};
    assign f.rdReady = !scanHold;
    assign step      = f.rdValid && f.rdReady;
    assign tmsB      = f.rdData[1];
    assign tdiB      = f.rdData[0];

    jib_fifo #(
        .W (`JIB_FIFO_W),
        .D (`JIB_FIFO_D)
    ) u_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .f        (f)
    );

    // ---------------------------------------------
    // Instruction decode
    // ---------------------------------------------
    logic bsrSel;
    logic testMode;
    logic latchHeld;

    always_comb begin
        bsrSel    = 1'b0;
        testMode  = 1'b0;
        latchHeld = 1'b0;
        case (q.instr)
            `JIB_OP_EXTEST: begin
                bsrSel    = 1'b1;
                testMode  = 1'b1;
                latchHeld = 1'b1;
            end
            `JIB_OP_HIGHZ: begin
                testMode  = 1'b1;
            end
            `JIB_OP_SAMPLE: begin
                bsrSel    = 1'b1;
            end
            `JIB_OP_DRVT: begin
                bsrSel    = 1'b1;
                testMode  = 1'b1;
                latchHeld = 1'b1;
            end
            `JIB_OP_SHUTDN: begin
                testMode  = 1'b1;
                latchHeld = 1'b1;
            end
            `JIB_OP_DRVS: begin
                bsrSel    = 1'b1;
            end
            default: begin
                bsrSel    = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------
    // Tap controller walk
    // ---------------------------------------------
    function automatic jib_tap_t nextTap(jib_tap_t s, logic m);
        jib_tap_t n;
        n = s;
        case (s)
            TLR:     n = m ? TLR   : RTI;
            RTI:     n = m ? SELDR : RTI;
            SELDR:   n = m ? SELIR : CAPDR;
            CAPDR:   n = m ? EX1DR : SHDR;
            SHDR:    n = m ? EX1DR : SHDR;
            EX1DR:   n = m ? UPDDR : PSDR;
            PSDR:    n = m ? EX2DR : PSDR;
            EX2DR:   n = m ? UPDDR : SHDR;
            UPDDR:   n = m ? SELDR : RTI;
            SELIR:   n = m ? TLR   : CAPIR;
            CAPIR:   n = m ? EX1IR : SHIR;
            SHIR:    n = m ? EX1IR : SHIR;
            EX1IR:   n = m ? UPDIR : PSIR;
            PSIR:    n = m ? EX2IR : PSIR;
            EX2IR:   n = m ? UPDIR : SHIR;
            UPDIR:   n = m ? SELDR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        d         = q;
        d.tckPrev = tckS;
        d.rstPrev = rstInS;
        d.kaTick  = 1'b0;
        // Full queue drops the edge and leaves a sticky flag
        if (riseE && !f.wrReady) begin
            d.lost = 1'b1;
        end
        // Keep-alive stands in for the stopped system clocks
        if (testMode) begin
            if (q.kaCnt == `JIB_KA_DIV) begin
                d.kaCnt  = 3'h0;
                d.kaTick = 1'b1;
            end else begin
                d.kaCnt  = q.kaCnt + 3'h1;
            end
        end else begin
            d.kaCnt = 3'h0;
        end
        // Release of the reset pin samples the priority pins
        if (!latchHeld && rstInS && !q.rstPrev) begin
            d.drv = iplS;
        end
        if (q.tap == TLR) begin
            d.ir    = `JIB_OP_BYPASS;
            d.instr = `JIB_OP_BYPASS;
        end
        if (step) begin
            case (q.tap)
                CAPIR: d.ir = `JIB_IR_CAPT;
                SHIR:  d.ir = {tdiB, q.ir[`JIB_IR_W-1:1]};
                CAPDR: begin
                    if (bsrSel) begin
                        d.bsr = sysCapture;
                    end else begin
                        d.byp = 1'b0;
                    end
                end
                SHDR: begin
                    if (bsrSel) begin
                        d.bsr = {tdiB, q.bsr[`JIB_BSR_LEN-1:1]};
                    end else begin
                        d.byp = tdiB;
                    end
                end
                default: begin
                end
            endcase
            d.tap = nextTap(q.tap, tmsB);
        end
        if (fallE) begin
            d.tdoOe = (q.tap == SHIR) || (q.tap == SHDR);
            if (q.tap == SHIR) begin
                d.tdo = q.ir[0];
            end else if (bsrSel) begin
                d.tdo = q.bsr[0];
            end else begin
                d.tdo = q.byp;
            end
            if (q.tap == UPDIR) begin
                d.instr = q.ir;
            end
            if (q.tap == UPDDR) begin
                case (q.instr)
                    `JIB_OP_SAMPLE, `JIB_OP_EXTEST: begin
                        d.upd = q.bsr;
                    end
                    `JIB_OP_DRVT, `JIB_OP_DRVS: begin
                        // Zero picks the large driver
                        d.drv = q.bsr[`JIB_DRV_CELL +: `JIB_DRV_W];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Test reset comes last so it beats other writes to tap, ir, instr and tdoOe
        if (!trstS) begin
            d.tap   = TLR;
            d.ir    = `JIB_OP_BYPASS;
            d.instr = `JIB_OP_BYPASS;
            d.tdoOe = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q       <= '0;
            q.tap   <= TLR;
            q.ir    <= `JIB_OP_BYPASS;
            q.instr <= `JIB_OP_BYPASS;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    assign tdo           = q.tdo;
    assign tdoOe         = q.tdoOe;
    assign scanOut       = q.upd;
    assign driveSelect   = q.drv;
    // Decode is combinational, so an opcode acts from its update fall
    assign testOwnsPins  = testMode;
    assign pinsHighZ     = q.instr == `JIB_OP_HIGHZ;
    assign internalReset = testMode;
    assign keepAliveTick = q.kaTick;
    assign eventLost     = q.lost;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    // All checks sample on core_clk and rest while sys_rst is high
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    chk_ir_capture: assert property (
        step && q.tap == CAPIR |=> q.ir == 3'h1)
        else $error("capture-IR did not load 001");
    chk_trst_reset: assert property (
        !trstS |=> q.tap == TLR && q.instr == 3'h7)
        else $error("test reset did not reach reset state");
    chk_bypass_zero: assert property (
        step && q.tap == CAPDR && !bsrSel |=> !q.byp)
        else $error("bypass stage not zeroed at capture");
    chk_tdo_idle: assert property (
        fallE && q.tap != SHIR && q.tap != SHDR |=> !tdoOe)
        else $error("tdo driven outside shift states");
    chk_extest_reset: assert property (
        fallE && q.tap == UPDIR && q.ir == 3'h0 |=> internalReset)
        else $error("extest without internal reset");
    chk_drvs_system: assert property (
        q.instr == 3'h6 |-> !internalReset && !testOwnsPins)
        else $error("system drive-select took the pins");
    chk_drive_hold: assert property (
        latchHeld && !(fallE && q.tap == UPDDR) |=> $stable(q.drv))
        else $error("drive latch moved while held");
    chk_pin_load: assert property (
        !latchHeld && rstInS && !q.rstPrev |=> q.drv == $past(iplS))
        else $error("drive latch missed priority pins");
    chk_bsr_shift: assert property (
        step && q.tap == SHDR && bsrSel
        |=> q.bsr[182:0] == $past(q.bsr[183:1]))
        else $error("scan chain did not shift");
    chk_keep_alive: assert property (
        testMode [*8] |-> ##[0:8] (keepAliveTick || !testMode))
        else $error("keep-alive tick missing");
    chk_highz_pins: assert property (
        q.instr == 3'h1 |-> pinsHighZ && !bsrSel && testOwnsPins)
        else $error("highz instruction misdecoded");

    // Shift, update, reset-state and sample behaviour
    chk_ir_shift: assert property (
        step && q.tap == SHIR && trstS
        |=> q.ir == {$past(tdiB), $past(q.ir[2:1])})
        else $error("instruction register did not shift");
    chk_tdo_shift: assert property (
        fallE && q.tap == SHDR && trstS |=> tdoOe)
        else $error("tdo not driven in shift-DR");
    chk_drive_update: assert property (
        fallE && q.tap == UPDDR && q.instr == 3'h3
        |=> q.drv == $past(q.bsr[2:0]))
        else $error("drive latch missed scan data");
    chk_tlr_bypass: assert property (
        q.tap == TLR |=> q.instr == 3'h7)
        else $error("reset state did not select bypass");
    chk_sample_quiet: assert property (
        q.instr == 3'h2 |-> !internalReset && !testOwnsPins)
        else $error("sample disturbed the system");

    cov_highz: cover property (fallE && q.tap == UPDIR && q.ir == 3'h1);
    cov_drvt: cover property (fallE && q.tap == UPDDR && q.instr == 3'h3);
    cov_sample: cover property (step && q.tap == CAPDR && q.instr == 3'h2);
    cov_lost: cover property (riseE && !f.wrReady);
    cov_extest: cover property (fallE && q.tap == UPDDR && q.instr == 3'h0);
endmodule

// *** sim/jib_tester.sv ***
// Purpose: tester model that drives the test access pins
// Assumes: tck edges placed on falling core_clk edges
// Notes:   tck stands low outside frames; tms and tdi idle high
`timescale 1ns/1ns
module jib_tester (
    // Clocking
    input  wire logic core_clk,
    // Test pins
    input  wire logic tdo,
    input  wire logic tdoOe,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstN
);
    logic lastOe;
    logic oeAll;

    initial begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b1;
        trstN  = 1'b1;
        oeAll  = 1'b1;
        lastOe = 1'b0;
    end

    // ------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------
    // Edges locked to core_clk stand in for bus clock sync
    task automatic tick(input logic m, input logic d, output logic q);
        @(negedge core_clk);
        tms = m;
        tdi = d;
        repeat (4) @(negedge core_clk);
        q      = tdo;
        lastOe = tdoOe;
        tck    = 1'b1;
        repeat (4) @(negedge core_clk);
        tck = 1'b0;
        // Released lines fall back to their pull-ups
        tms = 1'b1;
        tdi = 1'b1;
    endtask

    task automatic to_reset();
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask

    // Capture then update, no shift
    task automatic ir_noshift();
        logic       q;
        logic [5:0] p;
        p = 6'h1b;
        for (int i = 0; i < 6; i++) tick(p[i], 1'b1, q);
    endtask

    task automatic shift_ir(input logic [2:0] op, output logic [2:0] cap);
        logic q;
        for (int i = 0; i < 4; i++) tick(i < 2, 1'b1, q);
        for (int i = 0; i < 3; i++) begin
            tick(i == 2, op[i], cap[i]);
            oeAll = oeAll & lastOe;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask

    task automatic shift_dr(input logic [183:0] din, input int n,
                            output logic [183:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < 3; i++) tick(i == 0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
            oeAll = oeAll & lastOe;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask

    task automatic pulse_trst();
        @(negedge core_clk);
        trstN = 1'b0;
        repeat (6) @(negedge core_clk);
        trstN = 1'b1;
    endtask
endmodule

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the instruction behaviour block
// Assumes: tester model drives the test pins at 360 ns
// Notes:   one task per scenario; all stimulus on falling core_clk
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    samplesChecked++; \
    if ((g) !== (e)) begin \
        nMismatch++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
end
module testbench;
    import jib_pkg::*;
    logic         core_clk = 1'b0;
    logic         sys_rst, tck, tms, tdi, trstN, tdo, tdoOe;
    logic         resetInputPinN, scanHold, eventLost, testOwnsPins;
    logic         pinsHighZ, internalReset, keepAliveTick, own;
    logic [2:0]   interruptPriorityPins, driveSelect, cap;
    logic [183:0] sysCapture, scanOut, dout;
    logic [183:0] patA = {23{8'ha5}};
    logic [183:0] patB = {23{8'h3c}};
    logic [183:0] patC = {23{8'h96}};
    int           nMismatch = 0;
    int           samplesChecked = 0;
    int           ka;

    always #20 core_clk = ~core_clk;

    jib_core dut (.core_clk, .sys_rst, .tck, .tms, .tdi, .trstN, .tdo,
        .tdoOe, .resetInputPinN, .interruptPriorityPins, .sysCapture,
        .scanHold, .eventLost, .scanOut, .driveSelect, .testOwnsPins,
        .pinsHighZ, .internalReset, .keepAliveTick);
    jib_tester tester (.core_clk, .tdo, .tdoOe, .tck, .tms, .tdi, .trstN);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask

    // Pulses land every 8 cycles, so 16 samples see exactly two
    task automatic count_ka(output int n);
        n = 0;
        repeat (16) begin
            @(negedge core_clk);
            n += keepAliveTick;
        end
    endtask

    task automatic pulse_rip(input logic [2:0] pri);
        @(negedge core_clk);
        interruptPriorityPins = pri;
        resetInputPinN = 1'b0;
        repeat (4) @(negedge core_clk);
        resetInputPinN = 1'b1;
        settle();
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_power_up();
        interruptPriorityPins = 3'h5;
        resetInputPinN = 1'b1;
        settle();
        `CHK("driveSelect", 3'h5, driveSelect);
        `CHK("tdoOe", 1'b0, tdoOe);
        `CHK("testOwnsPins", 1'b0, testOwnsPins);
        $display("test_power_up done");
    endtask

    task automatic test_bypass();
        tester.to_reset();
        tester.shift_dr({182'h0, 2'h3}, 2, dout);
        `CHK("bypass out", 2'h2, dout[1:0]);
        `CHK("oe in shift", 1'b1, tester.oeAll);
        `CHK("tdoOe idle", 1'b0, tdoOe);
        $display("test_bypass done");
    endtask

    task automatic test_highz_path();
        tester.ir_noshift();
        settle();
        `CHK("pinsHighZ", 1'b1, pinsHighZ);
        `CHK("internalReset", 1'b1, internalReset);
        count_ka(ka);
        `CHK("keep-alive", 2, ka);
        tester.shift_dr({182'h0, 2'h3}, 2, dout);
        `CHK("highz bypass", 2'h2, dout[1:0]);
        tester.to_reset();
        `CHK("pinsHighZ off", 1'b0, pinsHighZ);
        $display("test_highz_path done");
    endtask

    task automatic test_decode();
        logic [2:0] op;
        for (int i = 0; i < 8; i++) begin
            op = i[2:0];
            own = (op == 3'h0) || (op == 3'h1) || (op == 3'h3)
                || (op == 3'h4);
            tester.shift_ir(op, cap);
            settle();
            `CHK("captured ir", 3'h1, cap);
            `CHK("testOwnsPins", own, testOwnsPins);
            `CHK("internalReset", own, internalReset);
            `CHK("pinsHighZ", op == 3'h1, pinsHighZ);
            count_ka(ka);
            `CHK("keep-alive", own ? 2 : 0, ka);
            tester.to_reset();
            `CHK("back to bypass", 1'b0, testOwnsPins);
        end
        $display("test_decode done");
    endtask

    task automatic test_sample_extest();
        sysCapture = patA;
        tester.shift_ir(3'h2, cap);
        tester.shift_dr(patB, 184, dout);
        settle();
        `CHK("sampled pins", patA, dout);
        `CHK("no disturbance", 1'b0, internalReset);
        `CHK("preload", patB, scanOut);
        tester.shift_ir(3'h0, cap);
        settle();
        `CHK("preload held", patB, scanOut);
        `CHK("extest owns", 1'b1, testOwnsPins);
        tester.shift_dr(patC, 184, dout);
        settle();
        `CHK("extest capture", patA, dout);
        `CHK("extest update", patC, scanOut);
        $display("test_sample_extest done");
    endtask

    task automatic test_drive_latch();
        tester.to_reset();
        tester.shift_ir(3'h3, cap);
        tester.shift_dr({patB[183:3], 3'h2}, 184, dout);
        settle();
        `CHK("drive capture", patA, dout);
        `CHK("driveSelect", 3'h2, driveSelect);
        pulse_rip(3'h7);
        `CHK("latch held", 3'h2, driveSelect);
        tester.shift_ir(3'h0, cap);
        tester.shift_ir(3'h4, cap);
        pulse_rip(3'h7);
        `CHK("latch held", 3'h2, driveSelect);
        `CHK("clamp", patC, scanOut);
        tester.to_reset();
        pulse_rip(3'h7);
        `CHK("system reload", 3'h7, driveSelect);
        repeat (128) @(negedge core_clk);
        tester.shift_ir(3'h6, cap);
        tester.shift_dr({patB[183:3], 3'h4}, 184, dout);
        settle();
        `CHK("driveSelect", 3'h4, driveSelect);
        `CHK("system owns", 1'b0, testOwnsPins);
        count_ka(ka);
        `CHK("no keep-alive", 0, ka);
        $display("test_drive_latch done");
    endtask

    task automatic test_trst();
        tester.shift_ir(3'h0, cap);
        tester.pulse_trst();
        settle();
        `CHK("trst owns", 1'b0, testOwnsPins);
        `CHK("trst tdoOe", 1'b0, tdoOe);
        tester.to_reset();
        $display("test_trst done");
    endtask

    // Held events pile up; the seventeenth is refused
    task automatic test_fifo_overflow();
        logic q;
        scanHold = 1'b1;
        repeat (16) tester.tick(1'b1, 1'b1, q);
        settle();
        `CHK("not lost", 1'b0, eventLost);
        tester.tick(1'b1, 1'b1, q);
        settle();
        `CHK("lost", 1'b1, eventLost);
        scanHold = 1'b0;
        repeat (24) @(negedge core_clk);
        tester.to_reset();
        tester.shift_ir(3'h7, cap);
        `CHK("after drain", 3'h1, cap);
        `CHK("sticky", 1'b1, eventLost);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        settle();
        `CHK("lost cleared", 1'b0, eventLost);
        `CHK("reload after reset", 3'h7, driveSelect);
        $display("test_fifo_overflow done");
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        resetInputPinN = 1'b0;
        interruptPriorityPins = 3'h0;
        sysCapture = '0;
        scanHold = 1'b0;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        settle();
        test_power_up();
        test_bypass();
        test_highz_path();
        test_decode();
        test_sample_extest();
        test_drive_latch();
        test_trst();
        test_fifo_overflow();
        final_report();
    end

    // Tests need roughly 9700 cycles; allow about six times that
    initial begin
        repeat (60000) @(posedge core_clk);
        nMismatch++;
        $display("watchdog expired");
        final_report();
    end
endmodule
